// ==== shared/dtoe_pkg.sv ====
package dtoe_pkg;
  // ---------------------------------------------------------------------
  // Register map (word indices; the byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam logic [7:0] MBIT_REG_IDX = 8'h17;
  localparam logic [7:0] FMASK1_REG_IDX = 8'h18;
  localparam logic [7:0] FMASK2_REG_IDX = 8'h19;
  localparam logic [7:0] FMASK3_REG_IDX = 8'h1A;
  localparam logic [7:0] FMASK4_REG_IDX = 8'h1B;
  localparam logic [7:0] CTRL_REG_IDX = 8'h1D;
  localparam logic [7:0] STAT_REG_IDX = 8'h1E;
  localparam int ADDR_W = 12;
  localparam int ADDR_LSB = 2;

  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int FEBE_VAL_HI = 7;
  localparam int FEBE_VAL_LO = 5;
  localparam int FEBE_EN_BIT = 4;
  localparam int MMASK_HI = 3;
  localparam int MMASK_LO = 1;
  localparam int PERR_BIT = 0;
  localparam int CBIT_MODE_BIT = 0;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] FMASK1_USED = 8'h0F;

  // ---------------------------------------------------------------------
  // Frame geometry: 7 subframes x 8 blocks x 85 bits
  // ---------------------------------------------------------------------
  localparam int N_SUB = 7;
  localparam int N_BLK = 8;
  localparam int BLK_LEN = 85;
  localparam int N_FBIT = 28;
  localparam int N_MBIT = 3;
  localparam int FEBE_SUB = 3;   // Fourth subframe carries far-end errors
  localparam logic [2:0] SUB_W = 3'h0;

  // Overhead bit kinds within one 85-bit block
  typedef enum logic [2:0] {
    dtoe_oh_x_e, dtoe_oh_p_e, dtoe_oh_m_e, dtoe_oh_f_e,
    dtoe_oh_c_e, dtoe_oh_none_e
  } dtoe_oh_t;
endpackage

// ==== rtl/dtoe_oh_mux.sv ====
`timescale 1ns/1ns
// Per-bit overhead modifier: picks the bit that leaves on the line.
module dtoe_oh_mux
  import dtoe_pkg::*;
(
  input wire dtoe_pkg::dtoe_oh_t kind,
  input wire logic bit_in,
  input wire logic mask_bit,
  input wire logic perr,
  input wire logic febe_sel,
  input wire logic febe_bit,
  output logic bit_out
);
  // ---------------------------------------------------------------------
  // Selection
  // ---------------------------------------------------------------------
  wire logic is_mf = (kind == dtoe_oh_m_e) || (kind == dtoe_oh_f_e);
  wire logic is_p = (kind == dtoe_oh_p_e);
  wire logic febe_bit_sel = febe_sel ? febe_bit : bit_in;
  assign bit_out = is_mf ? (bit_in ^ mask_bit) :
                   is_p ? (bit_in ^ perr) : febe_bit_sel;
endmodule

// ==== rtl/dtoe_tx_err_insert.sv ====
// Implementation choice: the APB register port.
`timescale 1ns/1ns
// Functional notes
// RULE1 - Override enabled: send software far-end error value
// RULE2 - Override off: far-end bits from receive side
// RULE3 - Override honoured only in C-bit parity format
// RULE4 - XOR each M-bit with its mask bit
// RULE5 - Mask bit 2 first M-bit, 0 last
// RULE6 - Software keeps masks zero for normal traffic
// RULE7 - Parity insert bit inverts computed P-bits
// RULE8 - XOR each F-bit with 28-bit mask
// RULE9 - F mask index 0 is first F-bit
// RULE10 - Masks stay active until software clears
module dtoe_tx_err_insert
  import dtoe_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dtoe_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_bit_in,
  input wire logic tx_bit_valid,
  input wire logic tx_frame_start,
  input wire logic rx_febe_in,
  output logic tx_bit_out,
  output logic tx_bit_out_valid
);
  import dtoe_pkg::*;

  // ---------------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a[ADDR_W-1:ADDR_LSB] == {{(ADDR_W-ADDR_LSB-8){1'b0}}, idx})
          && (a[ADDR_LSB-1:0] == '0);
  endfunction

  logic [7:0] mbit_reg, mbit_next;
  logic [27:0] fmask_reg, fmask_next;
  logic [7:0] ctrl_reg, ctrl_next;
  wire logic wr = psel && penable && pwrite;
  wire logic acc = psel && penable;
  wire logic h_m = hit(paddr, MBIT_REG_IDX);
  wire logic h_f1 = hit(paddr, FMASK1_REG_IDX);
  wire logic h_f2 = hit(paddr, FMASK2_REG_IDX);
  wire logic h_f3 = hit(paddr, FMASK3_REG_IDX);
  wire logic h_f4 = hit(paddr, FMASK4_REG_IDX);
  wire logic h_c = hit(paddr, CTRL_REG_IDX);
  wire logic h_s = hit(paddr, STAT_REG_IDX);
  wire logic mapped = h_m | h_f1 | h_f2 | h_f3 | h_f4 | h_c | h_s;
  wire logic [7:0] wb = pwdata[7:0];

  // Register next values; settings persist until rewritten
  // RULE10 masks persist
  assign mbit_next = (wr && h_m) ? wb : mbit_reg;
  assign ctrl_next = (wr && h_c) ? wb : ctrl_reg;
  assign fmask_next[27:24] = (wr && h_f1) ? wb[3:0] : fmask_reg[27:24];
  assign fmask_next[23:16] = (wr && h_f2) ? wb : fmask_reg[23:16];
  assign fmask_next[15:8] = (wr && h_f3) ? wb : fmask_reg[15:8];
  assign fmask_next[7:0] = (wr && h_f4) ? wb : fmask_reg[7:0];

  // ---------------------------------------------------------------------
  // Frame position tracking
  // ---------------------------------------------------------------------
  logic [2:0] sub_reg, sub_next;
  logic [2:0] blk_reg, blk_next;
  logic [6:0] pos_reg, pos_next;
  logic [4:0] fidx_reg, fidx_next;
  logic [1:0] midx_reg, midx_next;
  logic [1:0] febe_cnt_reg, febe_cnt_next;

  // Position seen by the current input bit (restart on frame start)
  wire logic [2:0] cur_sub = tx_frame_start ? SUB_W : sub_reg;
  wire logic [2:0] cur_blk = tx_frame_start ? 3'h0 : blk_reg;
  wire logic [6:0] cur_pos = tx_frame_start ? 7'h00 : pos_reg;
  wire logic [4:0] cur_f = tx_frame_start ? 5'h00 : fidx_reg;
  wire logic [1:0] cur_m = tx_frame_start ? 2'h0 : midx_reg;
  wire logic [1:0] cur_fe = tx_frame_start ? 2'h0 : febe_cnt_reg;
  wire logic oh_slot = (cur_pos == 7'h00);
  wire logic blk_odd = cur_blk[0];
  wire logic last_pos = (cur_pos == 7'(BLK_LEN - 1));
  wire logic last_blk = (cur_blk == 3'(N_BLK - 1));
  wire logic last_sub = (cur_sub == 3'(N_SUB - 1));

  // Overhead kind: block 0 X, 1 F1, 2 C1, 3 F0, 4 C2, 5 F0, 6 C3, 7 F1;
  // subframe 0/1 carry X, 2/3 carry P, 4-6 carry M in block 0
  dtoe_oh_t kind;
  always_comb begin
    kind = dtoe_oh_none_e;
    if (oh_slot) begin
      if (blk_odd) begin
        kind = dtoe_oh_f_e;
      end else if (cur_blk != 3'h0) begin
        kind = dtoe_oh_c_e;
      end else if (cur_sub == 3'h2 || cur_sub == 3'h3) begin
        kind = dtoe_oh_p_e;
      end else if (cur_sub >= 3'h4) begin
        kind = dtoe_oh_m_e;
      end else begin
        kind = dtoe_oh_x_e;
      end
    end
  end

  // RULE5 first M-bit uses mask bit 2
  wire logic m_mask = mbit_reg[MMASK_HI - 32'(cur_m)];
  // RULE9 index 0 is first F-bit
  wire logic f_mask = fmask_reg[cur_f];
  wire logic mask_sel = (kind == dtoe_oh_m_e) ? m_mask : f_mask;
  // RULE3 C-bit parity only
  wire logic cbit_mode = ctrl_reg[CBIT_MODE_BIT];
  wire logic is_febe = (kind == dtoe_oh_c_e) &&
                       (cur_sub == 3'(FEBE_SUB));
  // RULE1 override value
  // RULE2 receive side otherwise
  wire logic febe_sel = is_febe && cbit_mode && mbit_reg[FEBE_EN_BIT];
  wire logic [2:0] febe_val = mbit_reg[FEBE_VAL_HI:FEBE_VAL_LO];
  wire logic febe_bit = febe_val[2 - 32'(cur_fe)];
  // Far-end slots exist only in C-bit format; M13 keeps the C-bit as sent
  wire logic src_bit = (is_febe && cbit_mode) ? rx_febe_in : tx_bit_in;
  wire logic mod_bit;

  // RULE4 M-bit XOR
  // RULE7 parity invert
  // RULE8 F-bit XOR
  dtoe_oh_mux u_mux (
    .kind(kind),
    .bit_in(src_bit),
    .mask_bit(mask_sel),
    .perr(mbit_reg[PERR_BIT]),
    .febe_sel(febe_sel),
    .febe_bit(febe_bit),
    .bit_out(mod_bit)
  );

  // Position advance, held while no bit is offered
  assign pos_next = !tx_bit_valid ? pos_reg :
                    last_pos ? 7'h00 : cur_pos + 7'h01;
  assign blk_next = !tx_bit_valid ? blk_reg :
                    !last_pos ? cur_blk :
                    last_blk ? 3'h0 : cur_blk + 3'h1;
  assign sub_next = !tx_bit_valid ? sub_reg :
                    !(last_pos && last_blk) ? cur_sub :
                    last_sub ? 3'h0 : cur_sub + 3'h1;
  assign fidx_next = !tx_bit_valid ? fidx_reg :
                     (kind != dtoe_oh_f_e) ? cur_f :
                     (cur_f == 5'(N_FBIT - 1)) ? 5'h00 : cur_f + 5'h01;
  assign midx_next = !tx_bit_valid ? midx_reg :
                     (kind != dtoe_oh_m_e) ? cur_m :
                     (cur_m == 2'(N_MBIT - 1)) ? 2'h0 : cur_m + 2'h1;
  assign febe_cnt_next = !tx_bit_valid ? febe_cnt_reg :
                         !is_febe ? cur_fe :
                         (cur_fe == 2'h2) ? 2'h0 : cur_fe + 2'h1;

  // Read data mux; the status word shows the live frame position
  wire logic [7:0] rd_byte =
    h_m ? mbit_reg :
    h_f1 ? {4'h0, fmask_reg[27:24]} :
    h_f2 ? fmask_reg[23:16] :
    h_f3 ? fmask_reg[15:8] :
    h_f4 ? fmask_reg[7:0] :
    h_c ? ctrl_reg :
    h_s ? {2'h0, sub_reg, blk_reg} : 8'h00;

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  // Registers and APB answer; always zero wait state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mbit_reg <= REG_RST;
      fmask_reg <= '0;
      ctrl_reg <= REG_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      mbit_reg <= mbit_next;
      fmask_reg <= fmask_next;
      ctrl_reg <= ctrl_next;
      prdata <= {24'h00_0000, rd_byte};
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end

  // Framer datapath; one cycle of latency to the line
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sub_reg <= 3'h0;
      blk_reg <= 3'h0;
      pos_reg <= 7'h00;
      fidx_reg <= 5'h00;
      midx_reg <= 2'h0;
      febe_cnt_reg <= 2'h0;
      tx_bit_out <= 1'b0;
      tx_bit_out_valid <= 1'b0;
    end else begin
      sub_reg <= sub_next;
      blk_reg <= blk_next;
      pos_reg <= pos_next;
      fidx_reg <= fidx_next;
      midx_reg <= midx_next;
      febe_cnt_reg <= febe_cnt_next;
      tx_bit_out <= tx_bit_valid ? mod_bit : tx_bit_out;
      tx_bit_out_valid <= tx_bit_valid;
    end
  end
endmodule

// ==== verif/dtoe_chk_sva.sv ====
`timescale 1ns/1ns
// ------
// Port checker
// ------
module dtoe_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_bit_in,
  input wire logic tx_bit_valid,
  input wire logic tx_frame_start,
  input wire logic tx_bit_out,
  input wire logic tx_bit_out_valid
);
  import dtoe_pkg::*;
  logic [6:0] pos_reg;
  // Block position, so payload slots can be told from overhead
  always_ff @(posedge mclk) begin
    if (sys_rst) pos_reg <= 7'h00;
    else if (tx_bit_valid) pos_reg <= tx_frame_start ? 7'h01 :
      (pos_reg == 7'(BLK_LEN - 1)) ? 7'h00 : pos_reg + 7'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_out_valid: assert property (tx_bit_valid |=> tx_bit_out_valid)
    else $error("valid lost");
  a_out_hold: assert property (!tx_bit_valid |=> !tx_bit_out_valid &&
    $stable(tx_bit_out)) else $error("output moved while idle");
  a_payload_pass: assert property (
    tx_bit_valid && !tx_frame_start && pos_reg != 7'h00
    |=> tx_bit_out == $past(tx_bit_in)) else $error("payload altered");
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read data set");
  a_reset_idle: assert property (@(posedge mclk) disable iff (1'b0)
    sys_rst |=> !pready && !tx_bit_out_valid && !tx_bit_out)
    else $error("reset state wrong");
  c_err: cover property (pslverr);
  c_frame: cover property (tx_frame_start && tx_bit_valid);
  c_flip: cover property (tx_bit_out_valid && tx_bit_out != $past(tx_bit_in));
endmodule

bind dtoe_tx_err_insert dtoe_chk u_chk (.mclk(mclk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tx_bit_in(tx_bit_in), .tx_bit_valid(tx_bit_valid),
  .tx_frame_start(tx_frame_start), .tx_bit_out(tx_bit_out),
  .tx_bit_out_valid(tx_bit_out_valid));

// ==== verif/dtoe_line_rx.sv ====
`timescale 1ns/1ns
// ------
// Line receiver model
// ------
module dtoe_line_rx (
  input wire logic mclk,
  input wire logic line_valid,
  output int bit_count
);
  initial bit_count = 0;
  // Counts accepted bits; a dropped valid shows as a short frame
  always @(posedge mclk) begin
    if (line_valid) bit_count <= bit_count + 1;
  end
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  import dtoe_pkg::*;
  logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic tx_bit_in = 0, tx_bit_valid = 0, tx_frame_start = 0, rx_febe_in = 0;
  logic pready, pslverr, tx_bit_out, tx_bit_out_valid, er, c_pe, c_fen, c_cb;
  logic [7:0] rd;
  logic [2:0] c_mm = 3'h0, c_fv = 3'h0;
  logic [27:0] c_fm = 28'h0000000;
  int fail_count = 0, tests_run = 0, rx_count;
  // Address, write data, expected read, expected error
  // Status row: read-only, write dropped, position still zero
  logic [28:0] rows [6] = '{{12'h05C, 8'hFF, 8'hFF, 1'b0},
    {12'h060, 8'hFF, 8'h0F, 1'b0}, {12'h064, 8'hA5, 8'hA5, 1'b0},
    {12'h06C, 8'h5A, 8'h5A, 1'b0}, {12'h070, 8'h12, 8'h00, 1'b1},
    {12'h078, 8'h12, 8'h00, 1'b0}};
  always #25 mclk = ~mclk;
  dtoe_tx_err_insert DUT (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_bit_in(tx_bit_in), .tx_bit_valid(tx_bit_valid),
    .tx_frame_start(tx_frame_start), .rx_febe_in(rx_febe_in),
    .tx_bit_out(tx_bit_out), .tx_bit_out_valid(tx_bit_out_valid));
  dtoe_line_rx u_line (.mclk(mclk), .line_valid(tx_bit_out_valid),
    .bit_count(rx_count));
  // ------
  // Compare and bus tasks
  // ------
  task automatic bad(input string m);
    fail_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk_reg(input logic [7:0] g, input logic e,
      input logic [7:0] w, input logic we);
    tests_run++;
    if (g !== w || e !== we) bad("register read");
  endtask
  task automatic chk_bit(input logic g, w);
    tests_run++;
    if (g !== w) bad("line bit");
  endtask
  task automatic chk_cnt(input int g, w);
    tests_run++;
    if (g != w) bad("bit count");
  endtask
  // Waits on the slave's ready, never on a fixed latency
  task automatic apb(input logic [11:0] a, input logic w,
      input logic [7:0] d, output logic [7:0] r, output logic e);
    @(posedge mclk);
    {psel, penable, pwrite, paddr} <= {2'b10, w, a};
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    // Ready and read data are taken as they stood at the rising edge
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    {r, e} = {prdata[7:0], pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic cfg(input logic [2:0] mm, input logic [27:0] fm,
      input logic pe, fen, input logic [2:0] fv, input logic cb);
    {c_mm, c_fm, c_pe, c_fen, c_fv, c_cb} = {mm, fm, pe, fen, fv, cb};
    apb(12'h05C, 1'b1, {fv, fen, mm, pe}, rd, er);
    apb(12'h060, 1'b1, {4'h0, fm[27:24]}, rd, er);
    apb(12'h064, 1'b1, fm[23:16], rd, er);
    apb(12'h068, 1'b1, fm[15:8], rd, er);
    apb(12'h06C, 1'b1, fm[7:0], rd, er);
    apb(12'h074, 1'b1, {7'h00, cb}, rd, er);
  endtask
  // One M-frame; far-end input is the inverse of data so its use shows
  task automatic frame();
    int s, k;
    logic b, x, xp;
    xp = 1'b0;
    for (int i = 0; i <= 4760; i++) begin
      @(posedge mclk);
      {b, s, k} = {i[0] ^ i[2] ^ i[5], i / 680, (i % 680) / 85};
      x = b;
      if (i % 85 == 0) begin
        if (k == 0) x = (s == 2 || s == 3) ? b ^ c_pe :
          (s > 3 ? b ^ c_mm[6 - s] : b);
        else if (k % 2 == 1) x = b ^ c_fm[s * 4 + k / 2];
        else if (s == 3 && c_cb) x = c_fen ? c_fv[3 - k / 2] : ~b;
      end
      {tx_bit_in, rx_febe_in} <= {b, ~b};
      {tx_bit_valid, tx_frame_start} <= {i < 4760, i == 0};
      #1;
      if (i > 0) chk_bit(tx_bit_out, xp);
      xp = x;
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #2000000;
    bad("timeout");
    summarize();
  end
  // ------
  // Main sequence
  // ------
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (rows[j]) begin
      apb(rows[j][28:17], 1'b1, rows[j][16:9], rd, er);
      apb(rows[j][28:17], 1'b0, 8'h00, rd, er);
      chk_reg(rd, er, rows[j][8:1], rows[j][0]);
    end
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    apb(12'h05C, 1'b0, 8'h00, rd, er);
    chk_reg(rd, er, 8'h00, 1'b0);
    frame();
    cfg(3'h4, 28'h8000001, 1'b1, 1'b1, 3'h5, 1'b1);
    frame();
    frame();
    cfg(3'h1, 28'h0000102, 1'b0, 1'b0, 3'h7, 1'b1);
    frame();
    cfg(3'h2, 28'h4000000, 1'b1, 1'b1, 3'h7, 1'b0);
    frame();
    // The last valid bit reaches the line model one edge later
    @(posedge mclk);
    #1;
    chk_cnt(rx_count, 5 * 4760);
    summarize();
  end
endmodule
